// ---- asmc_pkg.sv ----
// constants for the async static memory controller (host side)
// assumes a 25 MHz system clock and a 16-bit, 18-bit-address static memory outside
// What this block does
// - read cycle lasts at least 55 or 70 ns by grade
// - address valid at least 50 or 60 ns before the write ends
// - both selects held at least 50 or 60 ns before the write ends
// - write data set 25 or 30 ns before the end, held 0 ns after
// - address valid no later than the start of the write interval
// - address stays stable 0 ns or more after the write ends
// - retention by secondary select low needs primary select held at a rail (high)
package asmc_pkg;
	localparam int unsigned CLK_PERIOD_NS      = 40;
	localparam int unsigned ADDR_W             = 18;
	localparam int unsigned DATA_W             = 16;
	// slow grade figures, covering both grades
	localparam int unsigned READ_CYCLE_MIN_NS  = 70;
	localparam int unsigned GATE_ACCESS_NS     = 40;
	localparam int unsigned DESELECT_FLOAT_NS  = 25;
	localparam int unsigned SELECT_WRITE_NS    = 60;
	localparam int unsigned DATA_OVERLAP_NS    = 30;
	localparam int unsigned DRIVE_AFTER_END_NS = 5;
	// cycle counts, least times rounded up
	localparam int unsigned READ_CYC   = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WRITE_CYC  = (SELECT_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OVERLAP_CYC = (DATA_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FLOAT_CYC  = (DESELECT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned GATE_CYC   = (GATE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W      = 3;
	// states, gray in listed order idle-rstrobe-wstrobe-recover-sleep
	typedef enum logic [2:0] {
		ASMC_IDLE    = 3'b000,
		ASMC_RSTROBE = 3'b001,
		ASMC_WSTROBE = 3'b011,
		ASMC_RECOVER = 3'b010,
		ASMC_SLEEP   = 3'b110
	} asmc_state_t;
endpackage : asmc_pkg

// ---- asmc_ctrl.sv ----
// controller that drives an async 16-bit static memory through its pins
// assumes all inputs synchronous to clk_sys; memory timing slow grade or faster
`timescale 1ns/1ns
`default_nettype none
module asmc_ctrl (
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	input  wire logic                           req_valid,
	input  wire logic                           req_write,
	input  wire logic [asmc_pkg::ADDR_W-1:0]    req_addr,
	input  wire logic [asmc_pkg::DATA_W-1:0]    req_wdata,
	input  wire logic [1:0]                     req_lane,
	input  wire logic                           sleep_req,
	output logic                                req_ready,
	output logic                                rd_valid,
	output logic [asmc_pkg::DATA_W-1:0]         rd_data,
	output logic [asmc_pkg::ADDR_W-1:0]         word_address,
	output logic                                select_n_primary,
	output logic                                select_high_secondary,
	output logic                                write_n,
	output logic                                out_gate_n,
	output logic                                low_lane_n,
	output logic                                high_lane_n,
	input  wire logic [asmc_pkg::DATA_W-1:0]    shared_data_bus_i,
	output logic [asmc_pkg::DATA_W-1:0]         shared_data_bus_o,
	output logic [1:0]                          shared_data_bus_oe
);
	asmc_pkg::asmc_state_t st_q, st_d;
	logic [asmc_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic                       wr_q, wr_d;
	logic                       rdy_q, rdy_d, rv_q, rv_d;
	logic [asmc_pkg::DATA_W-1:0] rdat_q, rdat_d, wdat_q, wdat_d;
	logic [asmc_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [1:0]                 lane_q, lane_d, oe_q, oe_d;
	logic                       sp_q, sp_d, ss_q, ss_d, we_q, we_d, og_q, og_d;

	// sized cycle count helper
	function automatic logic [asmc_pkg::CNT_W-1:0] cyc(input int unsigned n);
		cyc = asmc_pkg::CNT_W'(n - 1);
	endfunction : cyc

	// request accepted: valid, ready and at least one lane
	function automatic logic takes(input logic v, input logic r, input logic [1:0] l);
		takes = v && r && (l != 2'b00);
	endfunction : takes

	// next-state logic for the access sequencer
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		wr_d   = wr_q;
		rdy_d  = 1'b0;
		rv_d   = 1'b0;
		rdat_d = rdat_q;
		wdat_d = wdat_q;
		addr_d = addr_q;
		lane_d = lane_q;
		oe_d   = oe_q;
		sp_d   = sp_q;
		ss_d   = ss_q;
		we_d   = we_q;
		og_d   = og_q;
		case (st_q)
			asmc_pkg::ASMC_IDLE: begin
				sp_d = 1'b1;
				ss_d = 1'b1;
				we_d = 1'b1;
				og_d = 1'b1;
				oe_d = 2'b00;
				if (sleep_req) begin
					ss_d = 1'b0;
					st_d = asmc_pkg::ASMC_SLEEP;
				end else if (takes(req_valid, rdy_q, req_lane)) begin
					addr_d = req_addr;
					lane_d = ~req_lane;
					wr_d   = req_write;
					wdat_d = req_wdata;
					sp_d   = 1'b0;
					if (req_write) begin
						we_d = 1'b0;
						cnt_d = cyc(asmc_pkg::WRITE_CYC);
						st_d = asmc_pkg::ASMC_WSTROBE;
					end else begin
						og_d  = 1'b0;
						cnt_d = cyc(asmc_pkg::READ_CYC);
						st_d  = asmc_pkg::ASMC_RSTROBE;
					end
				end
			end
			asmc_pkg::ASMC_RSTROBE: begin
				if (cnt_q == '0) begin
					rdat_d = shared_data_bus_i;
					rv_d   = 1'b1;
					sp_d   = 1'b1;
					og_d   = 1'b1;
					lane_d = 2'b11;
					cnt_d  = cyc(asmc_pkg::FLOAT_CYC);
					st_d   = asmc_pkg::ASMC_RECOVER;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			asmc_pkg::ASMC_WSTROBE: begin
				// drive from the second strobe cycle until one cycle past the strobe rise
				oe_d = ~lane_q;
				if (cnt_q == '0) begin
					we_d  = 1'b1;
					cnt_d = cyc(asmc_pkg::FLOAT_CYC);
					st_d  = asmc_pkg::ASMC_RECOVER;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			asmc_pkg::ASMC_RECOVER: begin
				// address and data held past write end
				sp_d = 1'b1;
				lane_d = 2'b11;
				oe_d = 2'b00;
				if (cnt_q == '0) begin
					rdy_d = 1'b1;
					st_d  = asmc_pkg::ASMC_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			asmc_pkg::ASMC_SLEEP: begin
				ss_d = 1'b0;
				if (!sleep_req) begin
					ss_d  = 1'b1;
					cnt_d = cyc(asmc_pkg::READ_CYC);
					st_d  = asmc_pkg::ASMC_RECOVER;
				end
			end
			default: begin
				st_d = asmc_pkg::ASMC_IDLE;
			end
		endcase
		// ready only reasserts on return to idle
		if (st_q == asmc_pkg::ASMC_IDLE && !takes(req_valid, rdy_q, req_lane) && !sleep_req)
			rdy_d = 1'b1;
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q   <= asmc_pkg::ASMC_IDLE;
			cnt_q  <= '0;
			wr_q   <= 1'b0;
			rdy_q  <= 1'b0;
			rv_q   <= 1'b0;
			rdat_q <= '0;
			wdat_q <= '0;
			addr_q <= '0;
			lane_q <= 2'b11;
			oe_q   <= 2'b00;
			sp_q   <= 1'b1;
			ss_q   <= 1'b1;
			we_q   <= 1'b1;
			og_q   <= 1'b1;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			wr_q   <= wr_d;
			rdy_q  <= rdy_d;
			rv_q   <= rv_d;
			rdat_q <= rdat_d;
			wdat_q <= wdat_d;
			addr_q <= addr_d;
			lane_q <= lane_d;
			oe_q   <= oe_d;
			sp_q   <= sp_d;
			ss_q   <= ss_d;
			we_q   <= we_d;
			og_q   <= og_d;
		end
	end

	// pins straight from flops
	assign req_ready             = rdy_q;
	assign rd_valid              = rv_q;
	assign rd_data               = rdat_q;
	assign word_address          = addr_q;
	assign select_n_primary      = sp_q;
	assign select_high_secondary = ss_q;
	assign write_n               = we_q;
	assign out_gate_n            = og_q;
	assign low_lane_n            = lane_q[0];
	assign high_lane_n           = lane_q[1];
	assign shared_data_bus_o     = wdat_q;
	assign shared_data_bus_oe    = oe_q;

	// read gate spans the read cycle
	sequence s_read_held;
		!og_q [*2];
	endsequence
	// primary select and strobe span the write
	sequence s_write_held;
		(!we_q && !sp_q) [*2];
	endsequence

	// no drive while gate is low
	a_no_contention: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!og_q |-> oe_q == 2'b00) else $error("bus driven during read");
	a_gate_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!og_q |-> !wr_q && we_q) else $error("gate opened outside a read");
	a_read_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(og_q) |-> s_read_held) else $error("read strobe too short");
	a_write_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(we_q) |-> s_write_held) else $error("write too short");
	a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(we_q) |-> $stable(addr_q)) else $error("address moved at write end");
	// data stable over strobe, loaded at strobe fall
	a_data_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!we_q && !$fell(we_q) |-> $stable(wdat_q)) else $error("write data moved");
	// data still driven one cycle past write end
	a_data_after_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(we_q) |-> oe_q != 2'b00 && $stable(wdat_q)) else $error("write data dropped early");
	a_sleep_rail: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q == asmc_pkg::ASMC_SLEEP |-> !ss_q && sp_q) else $error("retention select");
	a_write_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!we_q |-> lane_q != 2'b11 && ss_q) else $error("write with no lane");
	// read result in the same cycle as gate release
	a_read_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(og_q) |-> rv_q) else $error("read result missing");
endmodule : asmc_ctrl
`default_nettype wire

// ---- asmc_mem_model.sv ----
// behavioural 256k x 16 static memory with two byte lanes
// assumes the bench resolves the shared bus from both drivers
`timescale 1ns/1ns
`default_nettype none
module asmc_mem_model #(
	parameter int ACC_NS = 70
) (
	input  wire logic [17:0] word_address,
	input  wire logic        select_n_primary,
	input  wire logic        select_high_secondary,
	input  wire logic        write_n,
	input  wire logic        out_gate_n,
	input  wire logic        low_lane_n,
	input  wire logic        high_lane_n,
	input  wire logic [15:0] bus,
	output logic      [15:0] mem_o,
	output logic      [1:0]  mem_oe
);
	logic [15:0] mem [0:262143];
	logic        sel;
	logic [1:0]  lane;
	assign sel  = !select_n_primary && select_high_secondary;
	assign lane = {!high_lane_n, !low_lane_n};
	assign mem_oe = (sel && write_n && !out_gate_n) ? lane : 2'b00;
	assign #(ACC_NS) mem_o = mem[word_address];
	always @(*) begin
		if (sel && !write_n && lane[0])
			mem[word_address][7:0] = bus[7:0];
		if (sel && !write_n && lane[1])
			mem[word_address][15:8] = bus[15:8];
	end
endmodule : asmc_mem_model
`default_nettype wire

// ---- asmc_ctrl_tb.sv ----
// self-checking bench for the static memory controller
// assumes the memory model is compiled first
`timescale 1ns/1ns
`default_nettype none
module asmc_ctrl_tb;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [17:0] req_addr = '0;
	logic [15:0] req_wdata = '0;
	logic [1:0]  req_lane = '0;
	logic        sleep_req = 1'b0;
	logic        req_ready, rd_valid, sel_p, sel_s, wr_n, gate_n, lo_n, hi_n;
	logic [17:0] addr;
	logic [15:0] rd_data, bus, d_o, m_o;
	logic [15:0] flt = 16'h5a5a;
	logic [1:0]  d_oe, m_oe, oe_seen;
	int          n_errors = 0, comparisons = 0, cyc = 0, n_low;
	always #20 clk_sys = ~clk_sys;
	asmc_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_lane(req_lane), .sleep_req(sleep_req), .req_ready(req_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .word_address(addr),
		.select_n_primary(sel_p), .select_high_secondary(sel_s), .write_n(wr_n),
		.out_gate_n(gate_n), .low_lane_n(lo_n), .high_lane_n(hi_n),
		.shared_data_bus_i(bus), .shared_data_bus_o(d_o), .shared_data_bus_oe(d_oe));
	asmc_mem_model #(.ACC_NS(70)) u_mem (.word_address(addr), .select_n_primary(sel_p),
		.select_high_secondary(sel_s), .write_n(wr_n), .out_gate_n(gate_n),
		.low_lane_n(lo_n), .high_lane_n(hi_n), .bus(bus), .mem_o(m_o), .mem_oe(m_oe));
	// released lanes show a toggling pattern, never a held value
	always @(posedge clk_sys) flt <= ~flt;
	always @(*) for (int i = 0; i < 2; i++)
		bus[i*8+:8] = d_oe[i] ? d_o[i*8+:8] : m_oe[i] ? m_o[i*8+:8] : flt[i*8+:8];
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	// watchdog and lane contention watch
	always @(negedge clk_sys) begin
		cyc++;
		check(d_oe & m_oe, 2'b00);
		if (cyc == 3000) begin
			n_errors++;
			close_out();
		end
	end
	// one request on the user side; a read waits for its answer
	task automatic req(input logic wr, input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] ln);
		@(posedge clk_sys);
		#1 {req_write, req_addr, req_wdata, req_lane} = {wr, a, d, ln};
		req_valid = 1'b1;
		do @(negedge clk_sys); while (req_ready !== 1'b1);
		@(posedge clk_sys);
		#1 req_valid = 1'b0;
		n_low = 0;
		oe_seen = 2'b00;
		while (!wr && rd_valid !== 1'b1) begin
			@(negedge clk_sys);
			n_low += (sel_p === 1'b0);
			oe_seen |= m_oe;
		end
	endtask : req
	// read and compare the enabled lanes only
	task automatic rd(input logic [17:0] a, input logic [1:0] ln, input logic [15:0] e);
		logic [15:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		req(1'b0, a, 16'h0000, ln);
		check(rd_data & m, e & m);
		check(oe_seen, ln);
		check(n_low >= 2, 1'b1);
		check(addr, a);
	endtask : rd
	// request held while blocked; primary must stay off
	task automatic hold(input logic slp, input logic [1:0] ln);
		@(posedge clk_sys);
		#1 {req_write, req_addr, req_lane, sleep_req} = {1'b1, 18'h0_0005, ln, slp};
		req_valid = 1'b1;
		repeat (2) @(negedge clk_sys);
		repeat (6) begin
			@(negedge clk_sys);
			check({sel_s, sel_p}, {~slp, 1'b1});
		end
		@(posedge clk_sys);
		#1 {req_valid, sleep_req} = 2'b00;
	endtask : hold
	task automatic s_reset;
		@(negedge clk_sys);
		check({sel_p, sel_s, wr_n, gate_n, lo_n, hi_n, d_oe}, 8'hfc);
	endtask : s_reset
	task automatic s_words;
		req(1'b1, 18'h0_0000, 16'ha5c3, 2'b11);
		req(1'b1, 18'h3_ffff, 16'h3c5a, 2'b11);
		rd(18'h0_0000, 2'b11, 16'ha5c3);
		rd(18'h3_ffff, 2'b11, 16'h3c5a);
	endtask : s_words
	task automatic s_lanes;
		req(1'b1, 18'h0_0005, 16'h1234, 2'b11);
		req(1'b1, 18'h0_0005, 16'hffab, 2'b01);
		req(1'b1, 18'h0_0005, 16'hcdff, 2'b10);
		for (int i = 1; i < 4; i++)
			rd(18'h0_0005, i[1:0], 16'hcdab);
	endtask : s_lanes
	task automatic s_refused;
		hold(1'b0, 2'b00);
		rd(18'h0_0005, 2'b11, 16'hcdab);
	endtask : s_refused
	task automatic s_sleep;
		hold(1'b1, 2'b11);
		rd(18'h0_0005, 2'b11, 16'hcdab);
	endtask : s_sleep
	initial begin
		repeat (15) @(posedge clk_sys);
		s_reset();
		@(posedge clk_sys);
		#1 rst_n = 1'b1;
		s_words();
		s_lanes();
		s_refused();
		s_sleep();
		close_out();
	end
endmodule : asmc_ctrl_tb
`default_nettype wire
